/* retire_and_prefetch_control.v */
`include "retire_consts.vh"
`default_nettype none
module retire_and_prefetch_control (
  // clock and reset
  input  wire        CLOCK_I,
  input  wire        SRST_I,
  // register port
  input  wire [3:0]  REG_ADDR_I,
  input  wire [31:0] REG_WDATA_I,
  input  wire        REG_WR_I,
  input  wire        REG_RD_I,
  output reg  [31:0] REG_RDATA_O,
  // decode dispatch
  input  wire        DISP_VALID_I,
  input  wire [3:0]  DISP_CLASS_I,
  input  wire [3:0]  DISP_GROUP_I,
  input  wire        DISP_DEST_ZERO_I,
  input  wire        DISP_MUL_OVF_I,
  input  wire        DISP_DOUBLE_I,
  input  wire        DISP_SRC_NEG_I,
  input  wire [10:0] DISP_EXP_A_I,
  input  wire [10:0] DISP_EXP_B_I,
  input  wire        DISP_NAN_INF_I,
  input  wire        DISP_TRAP_INEXACT_I,
  input  wire [10:0] DISP_RES_EXP_I,
  output wire        DISP_READY_O,
  output wire        DISP_DROP_O,
  output wire [2:0]  DISP_TAG_O,
  // execution completion
  input  wire        CMPL_VALID_I,
  input  wire [2:0]  CMPL_TAG_I,
  input  wire        CMPL_MISP_I,
  // retire and mispredict reports
  output reg  [3:0]  RET_COUNT_O,
  output reg  [2:0]  RET_HEAD_O,
  output reg         MISP_VALID_O,
  output reg  [2:0]  MISP_TAG_O,
  // zero-register load, after cache lookup
  input  wire        PF_VALID_I,
  input  wire [3:0]  PF_KIND_I,
  input  wire        PF_LEN_I,
  input  wire [31:0] PF_ADDR_I,
  input  wire        PF_HIT_I,
  input  wire        PF_HIT_DIRTY_I,
  input  wire        PF_EXC_I,
  // miss-address-file request
  output reg         MAF_ALLOC_O,
  output reg  [1:0]  MAF_CMD_O,
  output reg  [31:0] MAF_ADDR_O,
  output reg         MAF_WRITABLE_O,
  output reg         MAF_SET_DIRTY_O,
  output reg         MAF_EVICT_NEXT_O,
  output reg         PF_DISMISS_O,
  output reg         PF_EXC_O,
  // lock tracking
  input  wire        LOCK_LOAD_I,
  input  wire [31:0] LOCK_ADDR_I,
  input  wire        LOCK_CONTEST_I,
  output reg         LOCK_VALID_O
);

  // state
  reg  [2:0]  head_r;         // oldest entry
  reg  [2:0]  tail_r;         // next free entry
  reg  [3:0]  cnt_r;          // entries in use
  reg  [1:0]  ctrl_r;         // control register
  reg  [15:0] ret_total_r;    // retired instructions
  reg  [25:0] lock_blk_r;     // locked 64-byte block
  reg         rd_pend_r;      // read answer due
  reg  [3:0]  rd_addr_r;      // address of pending read

  // per-entry view
  wire [7:0]  ent_v;          // entry valid
  wire [7:0]  ent_ready;      // completed and old enough
  wire [7:0]  ent_rptq;       // mispredict awaiting report
  // combinational results
  reg  [3:0]  ret_n;          // retire count this cycle
  reg  [7:0]  ret_mask;       // entries retiring
  reg  [7:0]  rpt_sel;        // entry reported this cycle
  reg  [5:0]  min_stg;        // earliest retire stage of new entry
  reg  [5:0]  rpt_stg;        // mispredict report stage
  reg         early_ok;       // divide/sqrt early retire allowed
  reg         drop;           // removed at decode
  reg  [2:0]  idx;            // loop index
  reg         run;            // contiguous run still alive
  integer     k;              // loop index of the retire search
  integer     j;              // loop index of the report tag encoder

  wire        inexact_enable_status    = ctrl_r[`CTRL_INE];
  wire        pf_en  = ctrl_r[`CTRL_PFEN];
  wire        disp_acc = DISP_VALID_I && (cnt_r != 4'h8);
  wire        rd_now = REG_RD_I;

  assign DISP_READY_O = (cnt_r != 4'h8);
  assign DISP_DROP_O  = DISP_VALID_I && drop;
  assign DISP_TAG_O   = tail_r;

  // decode-time removal of zero-destination operates and of trap and exception barriers
  always @* begin
    case (DISP_GROUP_I)
      `GRP_INT_ARITH, `GRP_INT_LOGIC, `GRP_INT_MUL,
      `GRP_INT_SHIFT, `GRP_UQ_LOAD:
        drop = DISP_DEST_ZERO_I;
      `GRP_FP_IEEE, `GRP_FP_DTI, `GRP_FP_LEGACY, `GRP_FP_SQRTMOVE:
        drop = DISP_DEST_ZERO_I;
      `GRP_TRAP_BAR, `GRP_EXC_BAR:
        drop = 1'b1;
      `GRP_FP_CTRL_WR:
        drop = 1'b0;
      default:
        drop = 1'b0;
    endcase
  end

  // early retire check for divide and square root
  always @* begin
    early_ok = inexact_enable_status && !DISP_TRAP_INEXACT_I;
    if (DISP_NAN_INF_I) begin
      early_ok = 1'b0;
    end
    if (DISP_CLASS_I == `CLS_FSQRT) begin
      if (DISP_SRC_NEG_I) begin
        early_ok = 1'b0;
      end
    end else if (DISP_CLASS_I == `CLS_FDIV) begin
      if (DISP_EXP_A_I == 11'h000 || DISP_EXP_B_I == 11'h000) begin
        early_ok = 1'b0;
      end
      if (DISP_DOUBLE_I) begin
        if (DISP_RES_EXP_I >= `EXP_D_HI || DISP_RES_EXP_I <= `EXP_D_LO) begin
          early_ok = 1'b0;
        end
      end else if (DISP_RES_EXP_I >= `EXP_S_HI || DISP_RES_EXP_I <= `EXP_S_LO) begin
        early_ok = 1'b0;
      end
    end else begin
      early_ok = 1'b0;
    end
  end

  // earliest retire stage and report stage per class
  always @* begin
    rpt_stg = `STG_NEVER;
    case (DISP_CLASS_I)
      `CLS_ICBR, `CLS_IOP: min_stg = `STG_INT;
      `CLS_IMUL: min_stg = DISP_MUL_OVF_I ? `STG_IMUL_OVF : `STG_INT;
      `CLS_MEM, `CLS_BSR: min_stg = `STG_MEM;
      `CLS_JSR: begin
        min_stg = `STG_MEM;
        rpt_stg = `STG_RPT_JSR;
      end
      `CLS_FADD, `CLS_FMUL: min_stg = `STG_FP;
      `CLS_FCBR: begin
        min_stg = `STG_FP;
        rpt_stg = `STG_RPT_FCBR;
      end
      `CLS_FDIV: min_stg = early_ok ? `STG_FP :
        `STG_FP + (DISP_DOUBLE_I ? `REUSE_DIV_D : `REUSE_DIV_S);
      `CLS_FSQRT: min_stg = early_ok ? `STG_FP :
        `STG_FP + (DISP_DOUBLE_I ? `REUSE_SQRT_D : `REUSE_SQRT_S);
      default: min_stg = `STG_INT;
    endcase
    if (drop) begin
      min_stg = `STG_DECODE;
    end
  end

  // oldest contiguous ready group retires together
  always @* begin
    ret_n = 4'h0;
    ret_mask = 8'h00;
    rpt_sel = 8'h00;
    run = 1'b1;
    idx = head_r;
    for (k = 0; k < `ROB_DEPTH; k = k + 1) begin
      idx = head_r + k[2:0];
      if (run && ent_v[idx] && ent_ready[idx]) begin
        ret_mask[idx] = 1'b1;
        ret_n = ret_n + 4'h1;
      end else begin
        run = 1'b0;
      end
    end
    // oldest pending mispredict is reported first
    run = 1'b1;
    for (k = 0; k < `ROB_DEPTH; k = k + 1) begin
      idx = head_r + k[2:0];
      if (run && ent_v[idx] && ent_rptq[idx]) begin
        rpt_sel[idx] = 1'b1;
        run = 1'b0;
      end
    end
  end

  // one generated slot per reorder entry
  genvar g;
  generate
    for (g = 0; g < `ROB_DEPTH; g = g + 1) begin : slot
      reg       v_r;    // occupied
      reg       done_r; // execution finished
      reg       misp_r; // mispredicted
      reg       rep_r;  // mispredict already reported
      reg [5:0] stg_r;  // current pipeline stage
      reg [5:0] min_r;  // earliest retire stage
      reg [5:0] rpt_r;  // report stage
      wire      alloc = disp_acc && (tail_r == g);
      wire      cmpl  = CMPL_VALID_I && (CMPL_TAG_I == g) && v_r;
      assign ent_v[g]     = v_r;
      assign ent_ready[g] = done_r && (stg_r >= min_r);
      assign ent_rptq[g]  = misp_r && !rep_r && (stg_r >= rpt_r);
      // entry bookkeeping
      always @(posedge CLOCK_I) begin
        if (SRST_I) begin
          v_r    <= 1'b0;
          done_r <= 1'b0;
          misp_r <= 1'b0;
          rep_r  <= 1'b0;
          stg_r  <= 6'h00;
          min_r  <= 6'h00;
          rpt_r  <= 6'h00;
        end else if (alloc) begin
          v_r    <= 1'b1;
          done_r <= drop;
          misp_r <= 1'b0;
          rep_r  <= 1'b0;
          stg_r  <= `STG_DECODE;
          min_r  <= min_stg;
          rpt_r  <= rpt_stg;
        end else if (ret_mask[g]) begin
          v_r    <= 1'b0;
        end else begin
          // stage advances every cycle, held at its top
          if (v_r && stg_r != 6'h3f) begin
            stg_r <= stg_r + 6'h01;
          end
          if (cmpl) begin
            done_r <= 1'b1;
            misp_r <= CMPL_MISP_I;
          end
          if (rpt_sel[g]) begin
            rep_r <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // pointers, retire and mispredict outputs
  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      head_r       <= 3'h0;
      tail_r       <= 3'h0;
      cnt_r        <= 4'h0;
      ret_total_r  <= 16'h0000;
      RET_COUNT_O  <= 4'h0;
      RET_HEAD_O   <= 3'h0;
      MISP_VALID_O <= 1'b0;
      MISP_TAG_O   <= 3'h0;
    end else begin
      head_r      <= head_r + ret_n[2:0];
      tail_r      <= tail_r + {2'h0, disp_acc};
      cnt_r       <= cnt_r + {3'h0, disp_acc} - ret_n;
      ret_total_r <= ret_total_r + {12'h000, ret_n};
      RET_COUNT_O <= ret_n;
      RET_HEAD_O  <= head_r;
      MISP_VALID_O <= (rpt_sel != 8'h00);
      MISP_TAG_O  <= 3'h0;
      for (j = 0; j < `ROB_DEPTH; j = j + 1) begin
        if (rpt_sel[j]) begin
          MISP_TAG_O <= j[2:0];
        end
      end
    end
  end

  // zero-register loads become prefetches
  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      MAF_ALLOC_O      <= 1'b0;
      MAF_CMD_O        <= `MAF_READ;
      MAF_ADDR_O       <= 32'h00000000;
      MAF_WRITABLE_O   <= 1'b0;
      MAF_SET_DIRTY_O  <= 1'b0;
      MAF_EVICT_NEXT_O <= 1'b0;
      PF_DISMISS_O     <= 1'b0;
      PF_EXC_O         <= 1'b0;
    end else begin
      MAF_ALLOC_O      <= 1'b0;
      MAF_WRITABLE_O   <= 1'b0;
      MAF_SET_DIRTY_O  <= 1'b0;
      MAF_EVICT_NEXT_O <= 1'b0;
      PF_DISMISS_O     <= 1'b0;
      PF_EXC_O         <= PF_VALID_I && PF_EXC_I;
      if (PF_VALID_I && !PF_EXC_I) begin
        MAF_ADDR_O <= PF_ADDR_I;
        case (PF_KIND_I)
          `LK_SF: begin
            // modify intent: only a dirty hit or a disabled prefetch dismisses
            MAF_CMD_O <= `MAF_READ_MOD;
            if (PF_HIT_I && PF_HIT_DIRTY_I || !pf_en) begin
              PF_DISMISS_O <= 1'b1;
            end else begin
              MAF_ALLOC_O     <= 1'b1;
              MAF_WRITABLE_O  <= 1'b1;
              MAF_SET_DIRTY_O <= 1'b1;
            end
          end
          `LK_QUAD, `LK_PRIV: begin
            if (PF_KIND_I == `LK_QUAD || PF_LEN_I) begin
              // quadword forms: evict next
              MAF_CMD_O <= `MAF_READ_SPC;
              MAF_EVICT_NEXT_O <= !PF_HIT_I && pf_en;
            end else begin
              MAF_CMD_O <= `MAF_READ;
            end
            PF_DISMISS_O <= PF_HIT_I || !pf_en;
            MAF_ALLOC_O  <= !PF_HIT_I && pf_en;
          end
          `LK_BYTE, `LK_WORD, `LK_LONG, `LK_FF, `LK_GF, `LK_TF: begin
            MAF_CMD_O    <= `MAF_READ;
            PF_DISMISS_O <= PF_HIT_I || !pf_en;
            MAF_ALLOC_O  <= !PF_HIT_I && pf_en;
          end
          default: begin
            PF_DISMISS_O <= 1'b1;
          end
        endcase
      end
    end
  end

  // lock flag: a later prefetch to the block only hurts when contested
  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      LOCK_VALID_O <= 1'b0;
      lock_blk_r   <= 26'h0000000;
    end else if (LOCK_LOAD_I) begin
      LOCK_VALID_O <= 1'b1;
      lock_blk_r   <= LOCK_ADDR_I[31:6];
    end else if (LOCK_VALID_O && PF_VALID_I && LOCK_CONTEST_I
                 && PF_ADDR_I[31:6] == lock_blk_r) begin
      LOCK_VALID_O <= 1'b0;
    end
  end

  // register writes and read answer one cycle later
  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      ctrl_r      <= `CTRL_RST;
      rd_pend_r   <= 1'b0;
      rd_addr_r   <= 4'h0;
      REG_RDATA_O <= 32'h00000000;
    end else begin
      if (REG_WR_I && REG_ADDR_I == `REG_CTRL) begin
        ctrl_r <= REG_WDATA_I[1:0];
      end
      rd_pend_r <= rd_now;
      rd_addr_r <= REG_ADDR_I;
      REG_RDATA_O <= 32'h00000000;
      if (rd_now) begin
        case (REG_ADDR_I)
          `REG_CTRL:   REG_RDATA_O <= {30'h00000000, ctrl_r};
          `REG_STATUS: REG_RDATA_O <= {16'h0000, ent_v, 1'b0, head_r, cnt_r};
          `REG_COUNT:  REG_RDATA_O <= {16'h0000, ret_total_r};
          default:     REG_RDATA_O <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // retire_and_prefetch_control
`default_nettype wire

/* retire_consts.vh */
`ifndef RETIRE_CONSTS_VH
`define RETIRE_CONSTS_VH
// retire classes
`define CLS_ICBR  4'h0
`define CLS_IOP   4'h1
`define CLS_IMUL  4'h2
`define CLS_MEM   4'h3
`define CLS_BSR   4'h4
`define CLS_JSR   4'h5
`define CLS_FADD  4'h6
`define CLS_FMUL  4'h7
`define CLS_FCBR  4'h8
`define CLS_FDIV  4'h9
`define CLS_FSQRT 4'ha
// decode groups for zero-destination removal
`define GRP_INT_ARITH   4'h0
`define GRP_INT_LOGIC   4'h1
`define GRP_INT_MUL     4'h2
`define GRP_INT_SHIFT   4'h3
`define GRP_FP_IEEE     4'h4
`define GRP_FP_DTI      4'h5
`define GRP_FP_LEGACY   4'h6
`define GRP_FP_SQRTMOVE 4'h7
`define GRP_UQ_LOAD     4'h8
`define GRP_TRAP_BAR    4'h9
`define GRP_EXC_BAR     4'ha
`define GRP_MISC_OTHER  4'hb
`define GRP_FP_CTRL_WR  4'hc
`define GRP_OTHER       4'hf
// stages
`define STG_DECODE   6'h03
`define STG_INT      6'h07
`define STG_IMUL_OVF 6'h0d
`define STG_MEM      6'h0a
`define STG_FP       6'h0b
`define STG_RPT_FCBR 6'h07
`define STG_RPT_JSR  6'h08
`define STG_NEVER    6'h3f
// unit reuse latencies
`define REUSE_DIV_S  6'h09
`define REUSE_DIV_D  6'h0c
`define REUSE_SQRT_S 6'h0f
`define REUSE_SQRT_D 6'h1e
// result exponent limits
`define EXP_D_HI 11'h3ff
`define EXP_D_LO 11'h002
`define EXP_S_HI 11'h07f
`define EXP_S_LO 11'h382
// load kinds to a zero register
`define LK_BYTE  4'h0
`define LK_WORD  4'h1
`define LK_LONG  4'h2
`define LK_FF    4'h3
`define LK_GF    4'h4
`define LK_TF    4'h5
`define LK_SF    4'h6
`define LK_QUAD  4'h7
`define LK_PRIV  4'h8
// miss-address-file commands
`define MAF_READ     2'h0
`define MAF_READ_MOD 2'h1
`define MAF_READ_SPC 2'h2
// registers
`define REG_CTRL   4'h0
`define REG_STATUS 4'h4
`define REG_COUNT  4'h8
`define CTRL_INE   0
`define CTRL_PFEN  1
`define CTRL_RST   2'h3
// reorder depth
`define ROB_DEPTH 8
`endif

/* retire_and_prefetch_control_properties.sv */
`include "retire_consts.vh"
`default_nettype none
module rpc_properties (
  // clock, reset and register port
  input wire logic        CLOCK_I,
  input wire logic        SRST_I,
  input wire logic [3:0]  REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic        REG_WR_I,
  // decode side
  input wire logic        DISP_VALID_I,
  input wire logic [3:0]  DISP_GROUP_I,
  input wire logic        DISP_DEST_ZERO_I,
  input wire logic        DISP_DROP_O,
  // prefetch side
  input wire logic        PF_VALID_I,
  input wire logic [3:0]  PF_KIND_I,
  input wire logic        PF_LEN_I,
  input wire logic        PF_HIT_I,
  input wire logic        PF_HIT_DIRTY_I,
  input wire logic        PF_EXC_I,
  input wire logic        MAF_ALLOC_O,
  input wire logic [1:0]  MAF_CMD_O,
  input wire logic        MAF_WRITABLE_O,
  input wire logic        MAF_SET_DIRTY_O,
  input wire logic        MAF_EVICT_NEXT_O,
  input wire logic        PF_DISMISS_O,
  input wire logic        PF_EXC_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic      en_r;                               // shadow of the prefetch enable bit
  wire logic pf = PF_VALID_I && !PF_EXC_I && en_r; // a prefetch that must act
  // follow control writes so the enable is known here
  always @(posedge CLOCK_I) begin
    if (SRST_I) en_r <= 1'b1;
    else if (REG_WR_I && REG_ADDR_I == `REG_CTRL) en_r <= REG_WDATA_I[1];
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  property p_drop;
    DISP_VALID_I && DISP_DEST_ZERO_I && DISP_GROUP_I <= `GRP_UQ_LOAD |-> DISP_DROP_O;
  endproperty
  a_drop: assert property (p_drop) else $error("zero-dest op kept");
  property p_keep;
    DISP_VALID_I && !DISP_DEST_ZERO_I && DISP_GROUP_I <= `GRP_UQ_LOAD |-> !DISP_DROP_O;
  endproperty
  a_keep: assert property (p_keep) else $error("live op dropped");
  property p_misc;
    DISP_VALID_I && DISP_GROUP_I inside {`GRP_TRAP_BAR, `GRP_EXC_BAR} |-> DISP_DROP_O;
  endproperty
  a_misc: assert property (p_misc) else $error("barrier kept");
  property p_ctrl;
    DISP_VALID_I && DISP_GROUP_I inside {`GRP_FP_CTRL_WR, `GRP_MISC_OTHER} |-> !DISP_DROP_O;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control write dropped");
  property p_exc;
    PF_VALID_I && PF_EXC_I |=> PF_EXC_O && !MAF_ALLOC_O;
  endproperty
  a_exc: assert property (p_exc) else $error("load fault lost");
  property p_hit;
    pf && PF_HIT_I && PF_KIND_I != `LK_SF |=> PF_DISMISS_O && !MAF_ALLOC_O;
  endproperty
  a_hit: assert property (p_hit) else $error("hit prefetch performed");
  property p_mod;
    pf && PF_KIND_I == `LK_SF && !(PF_HIT_I && PF_HIT_DIRTY_I) |=> MAF_ALLOC_O
      && MAF_WRITABLE_O && MAF_SET_DIRTY_O && MAF_CMD_O == `MAF_READ_MOD;
  endproperty
  a_mod: assert property (p_mod) else $error("modify prefetch wrong");
  property p_evict;
    pf && !PF_HIT_I && (PF_KIND_I == `LK_QUAD || PF_KIND_I == `LK_PRIV && PF_LEN_I)
      |=> MAF_ALLOC_O && MAF_EVICT_NEXT_O && MAF_CMD_O == `MAF_READ_SPC;
  endproperty
  a_evict: assert property (p_evict) else $error("evict-next prefetch wrong");
  property p_norm;
    pf && !PF_HIT_I && (PF_KIND_I <= `LK_TF || PF_KIND_I == `LK_PRIV && !PF_LEN_I)
      |=> MAF_ALLOC_O && !MAF_WRITABLE_O && !MAF_EVICT_NEXT_O && MAF_CMD_O == `MAF_READ;
  endproperty
  a_norm: assert property (p_norm) else $error("normal prefetch wrong");
  property p_cause;
    MAF_ALLOC_O |-> $past(PF_VALID_I);
  endproperty
  a_cause: assert property (p_cause) else $error("allocation without load");
  c_drop: cover property (DISP_VALID_I && DISP_DROP_O);
  c_mod: cover property (MAF_SET_DIRTY_O);
  c_evict: cover property (MAF_EVICT_NEXT_O);
endmodule // rpc_properties
`default_nettype wire

/* pipe_partner.sv */
`default_nettype none
module pipe_partner (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // instruction taken into the reorder queue
  input  wire logic       take_i,
  input  wire logic [2:0] tag_i,
  // knobs: completion delay and mispredict flag
  input  wire logic [3:0] dly_i,
  input  wire logic       misp_i,
  // completion back to the block
  output var  logic       cmpl_valid_o,
  output var  logic [2:0] cmpl_tag_o,
  output var  logic       cmpl_misp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int         t = 0;   // cycle count
  int         due[$];  // completion time of each entry in issue order
  logic [3:0] tq[$];   // {mispredict, tag} in issue order
  initial {cmpl_valid_o, cmpl_tag_o, cmpl_misp_o} = '0;
  // finish each entry dly_i cycles after issue, at most one per cycle
  always @(posedge clk_i) begin
    t = t + 1;
    cmpl_valid_o <= 1'b0;
    if (srst_i) begin
      due.delete();
      tq.delete();
      cmpl_tag_o <= ~cmpl_tag_o;
    end else begin
      if (take_i) begin
        due.push_back(t + int'(dly_i));
        tq.push_back({misp_i, tag_i});
      end
      if (due.size() > 0 && due[0] <= t) begin
        cmpl_valid_o <= 1'b1;
        {cmpl_misp_o, cmpl_tag_o} <= tq.pop_front();
        void'(due.pop_front());
      end else begin
        cmpl_tag_o <= ~cmpl_tag_o;  // idle tag never repeats the last one
      end
    end
  end
endmodule // pipe_partner
`default_nettype wire

/* test_retire_and_prefetch_control.sv */
`include "retire_consts.vh"
`default_nettype none
module test_retire_and_prefetch_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLOCK_I, SRST_I, REG_WR_I, REG_RD_I, DISP_VALID_I, DISP_DEST_ZERO_I;
  logic        DISP_MUL_OVF_I, DISP_DOUBLE_I, DISP_SRC_NEG_I, DISP_NAN_INF_I;
  logic        DISP_TRAP_INEXACT_I, DISP_READY_O, DISP_DROP_O, CMPL_VALID_I, CMPL_MISP_I;
  logic        MISP_VALID_O, PF_VALID_I, PF_LEN_I, PF_HIT_I, PF_HIT_DIRTY_I, PF_EXC_I;
  logic        MAF_ALLOC_O, MAF_WRITABLE_O, MAF_SET_DIRTY_O, MAF_EVICT_NEXT_O;
  logic        PF_DISMISS_O, PF_EXC_O, LOCK_LOAD_I, LOCK_CONTEST_I, LOCK_VALID_O, pm;
  logic [1:0]  MAF_CMD_O;
  logic [2:0]  DISP_TAG_O, CMPL_TAG_I, RET_HEAD_O, MISP_TAG_O;
  logic [3:0]  REG_ADDR_I, DISP_CLASS_I, DISP_GROUP_I, RET_COUNT_O, PF_KIND_I, dly, rc;
  logic [10:0] DISP_EXP_A_I, DISP_EXP_B_I, DISP_RES_EXP_I;
  logic [31:0] REG_WDATA_I, REG_RDATA_O, PF_ADDR_I, MAF_ADDR_O, LOCK_ADDR_I, d;
  int          fails = 0, checked = 0, b, n;
  int          dc[9] = '{0, 0, 0, 3, 3, 3, 4, 4, 4};  // stage offset per class
  retire_and_prefetch_control u_dut (.*);
  // far side: completes every kept instruction
  pipe_partner u_pipe (.clk_i(CLOCK_I), .srst_i(SRST_I), .take_i(DISP_VALID_I &&
    DISP_READY_O && !DISP_DROP_O), .tag_i(DISP_TAG_O), .dly_i(dly), .misp_i(pm),
    .cmpl_valid_o(CMPL_VALID_I), .cmpl_tag_o(CMPL_TAG_I), .cmpl_misp_o(CMPL_MISP_I));
  initial begin
    CLOCK_I = 1'b0;
    forever #12.5 CLOCK_I = ~CLOCK_I;
  end
  task chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // register bus: one-cycle strobes, read data the cycle after
  task wr(input logic [3:0] a, input logic [31:0] v);
    REG_ADDR_I <= a;
    REG_WDATA_I <= v;
    REG_WR_I <= 1'b1;
    @(posedge CLOCK_I);
    REG_WR_I <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    @(posedge CLOCK_I);
    REG_RD_I <= 1'b0;
    #1 d = REG_RDATA_O;
  endtask
  // default operands: in range, no fault, double precision
  task clr;
    {DISP_DEST_ZERO_I, DISP_MUL_OVF_I, DISP_SRC_NEG_I, DISP_NAN_INF_I} <= '0;
    {DISP_TRAP_INEXACT_I, pm} <= '0;
    DISP_DOUBLE_I <= 1'b1;
    DISP_GROUP_I <= `GRP_OTHER;
    dly <= 4'h1;
    {DISP_EXP_A_I, DISP_EXP_B_I, DISP_RES_EXP_I} <= {11'h400, 11'h400, 11'h100};
    @(posedge CLOCK_I);
  endtask
  // dispatch class c (t: an int op right behind it), count cycles to retire or report
  task lat(input logic [3:0] c, input bit m, t, output int k);
    DISP_CLASS_I <= c;
    DISP_VALID_I <= 1'b1;
    if (t) begin
      @(posedge CLOCK_I);
      DISP_CLASS_I <= `CLS_IOP;
    end
    @(posedge CLOCK_I);
    DISP_VALID_I <= 1'b0;
    k = 0;
    do begin
      @(posedge CLOCK_I);
      #1 k++;
    end while ((m ? MISP_VALID_O : RET_COUNT_O != 4'h0) !== 1'b1 && k < 60);
    rc = RET_COUNT_O;
    repeat (m ? 40 : 4) @(posedge CLOCK_I);
  endtask
  // one zero-register load after lookup; outputs compared the cycle after
  task pf(input logic [3:0] k, input logic l, h, dt, x, en);
    logic [7:0] e;
    PF_KIND_I <= k;
    {PF_LEN_I, PF_HIT_I, PF_HIT_DIRTY_I, PF_EXC_I, PF_VALID_I} <= {l, h, dt, x, 1'b1};
    if (x) e = 8'h01;
    else if (!en || (k == `LK_SF ? h && dt : h)) e = 8'h02;
    else if (k == `LK_SF) e = 8'hb8;
    else if (k == `LK_QUAD || k == `LK_PRIV && l) e = 8'hc4;
    else e = 8'h80;
    @(posedge CLOCK_I);
    PF_VALID_I <= 1'b0;
    #1 chk("prefetch", e, {MAF_ALLOC_O, MAF_ALLOC_O ? MAF_CMD_O : 2'h0, MAF_WRITABLE_O,
      MAF_SET_DIRTY_O, MAF_EVICT_NEXT_O, PF_DISMISS_O, PF_EXC_O});
  endtask
  // cut a hang short
  initial begin
    repeat (20000) @(posedge CLOCK_I);
    fails++;
    report_and_stop;
  end
  initial begin
    {SRST_I, REG_WR_I, REG_RD_I, DISP_VALID_I, DISP_DEST_ZERO_I, DISP_MUL_OVF_I} = '1;
    {REG_WR_I, REG_RD_I, DISP_VALID_I, DISP_DEST_ZERO_I, DISP_MUL_OVF_I} = '0;
    {DISP_DOUBLE_I, DISP_SRC_NEG_I, DISP_NAN_INF_I, DISP_TRAP_INEXACT_I, pm} = '0;
    {PF_VALID_I, PF_LEN_I, PF_HIT_I, PF_HIT_DIRTY_I, PF_EXC_I, LOCK_LOAD_I} = '0;
    {LOCK_CONTEST_I, REG_ADDR_I, DISP_CLASS_I, DISP_GROUP_I, PF_KIND_I, dly} = '0;
    {DISP_EXP_A_I, DISP_EXP_B_I, DISP_RES_EXP_I, REG_WDATA_I} = '0;
    {PF_ADDR_I, LOCK_ADDR_I} = {32'h0000_1040, 32'h0000_2000};
    repeat (20) @(posedge CLOCK_I);
    SRST_I <= 1'b0;
    @(posedge CLOCK_I);
    rd(`REG_CTRL);
    chk("ctrl reset", 32'h3, d);
    rd(4'hc);
    chk("unmapped read", 32'h0, d);
    wr(4'hc, 32'hffff_ffff);
    wr(`REG_CTRL, 32'h1);
    rd(`REG_CTRL);
    chk("ctrl write", 32'h1, d);
    wr(`REG_CTRL, 32'h3);
    $display("test registers done");
    clr;
    lat(`CLS_IOP, 0, 0, b);
    for (int c = 0; c < 9; c++) begin
      clr;
      lat(c[3:0], 0, 0, n);
      chk("class retire", dc[c], n - b);
    end
    clr;
    DISP_MUL_OVF_I <= 1'b1;
    lat(`CLS_IMUL, 0, 0, n);
    chk("ovf multiply retire", 6, n - b);
    clr;
    lat(`CLS_FADD, 0, 1, n);
    chk("order retire", 3, n - b);
    chk("group size", 2, rc);
    clr;
    dly <= 4'ha;
    lat(`CLS_IOP, 0, 0, n);
    chk("slow retire", 7, n - b);
    clr;
    DISP_DEST_ZERO_I <= 1'b1;
    DISP_GROUP_I <= `GRP_INT_ARITH;
    lat(`CLS_IOP, 0, 0, n);
    chk("drop retire", 1, n < b && rc === 4'h1);
    $display("test retire stages done");
    for (int i = 0; i < 11; i++) begin
      clr;
      case (i)
        1: DISP_EXP_A_I <= 11'h000;
        2: DISP_EXP_B_I <= 11'h000;
        3: DISP_NAN_INF_I <= 1'b1;
        4: DISP_TRAP_INEXACT_I <= 1'b1;
        5: DISP_RES_EXP_I <= `EXP_D_HI;
        6: DISP_RES_EXP_I <= `EXP_D_LO;
        7: DISP_DOUBLE_I <= 1'b0;
        8: wr(`REG_CTRL, 32'h2);
        9: DISP_SRC_NEG_I <= 1'b1;
        default: ;
      endcase
      lat(i > 8 ? `CLS_FSQRT : `CLS_FDIV, 0, 0, n);
      if (i == 8) wr(`REG_CTRL, 32'h3);
      chk("divide retire", i == 0 || i == 10 ? 4 : i == 7 ? 13 : i == 9 ? 34 : 16, n - b);
    end
    $display("test early retire done");
    for (int i = 0; i < 3; i++) begin
      clr;
      pm <= 1'b1;
      lat(i == 0 ? `CLS_FCBR : i == 1 ? `CLS_JSR : `CLS_IOP, 1, 0, n);
      chk("mispredict report", i == 0 ? b : i == 1 ? b + 1 : 60, n);
    end
    $display("test mispredict done");
    for (int g = 0; g < 14; g++) begin
      clr;
      DISP_DEST_ZERO_I <= g != 13;
      DISP_GROUP_I <= g == 13 ? 4'h0 : g[3:0];
      DISP_VALID_I <= 1'b1;
      #1 chk("decode drop", g < 11, DISP_DROP_O);
      @(posedge CLOCK_I);
      DISP_VALID_I <= 1'b0;
    end
    repeat (30) @(posedge CLOCK_I);
    $display("test decode removal done");
    for (int i = 0; i < 72; i++) pf(i % 9, i / 9 % 2, i / 18 % 2, i / 36, 0, 1);
    pf(`LK_QUAD, 0, 0, 0, 1, 1);
    wr(`REG_CTRL, 32'h1);
    for (int k = 0; k < 9; k++) pf(k[3:0], 0, 0, 0, 0, 0);
    wr(`REG_CTRL, 32'h3);
    $display("test prefetch done");
    LOCK_LOAD_I <= 1'b1;
    @(posedge CLOCK_I);
    LOCK_LOAD_I <= 1'b0;
    PF_ADDR_I <= 32'h0000_2010;
    pf(`LK_BYTE, 0, 1, 0, 0, 1);
    @(posedge CLOCK_I);
    #1 chk("lock uncontested", 1, LOCK_VALID_O);
    LOCK_CONTEST_I <= 1'b1;
    pf(`LK_BYTE, 0, 1, 0, 0, 1);
    @(posedge CLOCK_I);
    #1 chk("lock contested", 0, LOCK_VALID_O);
    $display("test lock done");
    report_and_stop;
  end
endmodule // test_retire_and_prefetch_control
bind retire_and_prefetch_control rpc_properties u_props (.*);
`default_nettype wire
